// [blkstat_host.sv]
// host processor model: register reads and check-byte writes
// assumes strobes are taken on the rising edge and read data follows one cycle later
`timescale 1ns/100ps
`default_nettype none
module blkstat_host
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            rd_o,
    output logic            wr_o,
    output logic      [3:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial
    begin
        {rd_o, wr_o} = 2'h0;
        addr_o = 4'h0;
        wdata_o = 8'h00;
    end

    // one strobe per access; data is sampled just after the edge that registers it
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk_i);
        rd_o <= !w;
        wr_o <= w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        #1 q = rdata_i;
    endtask
endmodule // blkstat_host
`default_nettype wire

// [blkstat_pkg.sv]
// package for the corrected-block status and group check logic
// assumes a single 200 MHz clock domain
package blkstat_pkg;
    localparam logic [3:0]  ADDR_STATUS      = 4'h1;
    localparam logic [3:0]  ADDR_BLOCK_NUM   = 4'h2;
    localparam logic [3:0]  ADDR_CHECK_DATA  = 4'h6;
    // serial path not built here; kept so a later serial front end shares them
    localparam logic [7:0]  SERIAL_ADDR_DATA = 8'hFB;
    localparam int          SERIAL_STAT_BITS = 16;
    localparam int          BIT_VPASS        = 7;
    localparam int          BIT_BSYNC        = 6;
    localparam int          BIT_FSYNC        = 5;
    localparam int          BIT_ERROR        = 4;
    localparam int          BIT_PARITY       = 3;
    localparam int          BIT_HEAD         = 2;
    localparam int          BIT_CHECK_PASS   = 1;
    localparam int          BIT_REALTIME     = 0;
    localparam logic [7:0]  STATUS_RESET     = 8'h02;
    localparam logic [7:0]  BLOCK_NUM_RESET  = 8'h00;
    localparam logic [7:0]  PARITY_NUM_MAX   = 8'h51;
    localparam logic [15:0] CHECK_POLY       = 16'h1021;
    localparam logic [15:0] CHECK_RESET      = 16'h0000;
    localparam logic [7:0]  CHECK_UNIT_BYTE  = 8'h01;
    localparam logic [7:0]  READ_ZERO        = 8'h00;
endpackage : blkstat_pkg

// [blkstat_regs.sv]
// status, block number and group check register bank
// assumes host accesses are synchronous single-cycle strobes
`timescale 1ns/100ps
`default_nettype none
module blkstat_regs
    import blkstat_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic       BLOCK_READY_I,
    input  wire logic       VERTICAL_PASS_FLAG_I,
    input  wire logic       BLOCK_SYNC_FLAG_I,
    input  wire logic       FRAME_SYNC_FLAG_I,
    input  wire logic       BLOCK_ERROR_I,
    input  wire logic       PARITY_BLOCK_FLAG_I,
    input  wire logic       FRAME_HEAD_I,
    input  wire logic       REALTIME_BLOCK_FLAG_I,
    input  wire logic [7:0] BLOCK_INDEX_BITS_I,
    input  wire logic       READ_ANYTIME_I,
    input  wire logic       GROUP_CHECK_CLEAR_I,
    input  wire logic       RD_I,
    input  wire logic       WR_I,
    input  wire logic [3:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    output logic      [7:0] RDATA_O,
    output logic            INT_N_O,
    output logic            GROUP_CHECK_PASS_O
);
    import blkstat_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  status;
    logic [7:0]  block_num;
    logic [15:0] check;
    logic        int_n;
    logic        pass;
    logic [7:0]  rdata;
    logic [7:0]  next_status;
    logic [7:0]  next_block_num;
    logic [15:0] next_check;
    logic        next_int_n;
    logic        next_pass;
    logic [7:0]  next_rdata;
    logic        int_fall;

    // one byte of the group check, msb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
        begin
            if (r[15] ^ d[i])
                r = {r[14:0], 1'b0} ^ CHECK_POLY;
            else
                r = {r[14:0], 1'b0};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_int_n = ~BLOCK_READY_I;
        int_fall   = int_n & ~next_int_n;
        next_check = check;
        if (GROUP_CHECK_CLEAR_I)
            next_check = CHECK_RESET;
        else if (WR_I && ADDR_I == ADDR_CHECK_DATA)
            next_check = crc_byte(check, WDATA_I);
        next_pass = (next_check == CHECK_RESET);
        next_status = status;
        next_block_num = block_num;
        if (int_fall)
        begin
            next_status[BIT_VPASS]    = VERTICAL_PASS_FLAG_I;
            next_status[BIT_BSYNC]    = BLOCK_SYNC_FLAG_I;
            next_status[BIT_FSYNC]    = FRAME_SYNC_FLAG_I;
            next_status[BIT_ERROR]    = BLOCK_ERROR_I;
            next_status[BIT_PARITY]   = PARITY_BLOCK_FLAG_I;
            next_status[BIT_HEAD]     = FRAME_HEAD_I;
            next_status[BIT_REALTIME] = REALTIME_BLOCK_FLAG_I;
            next_block_num = BLOCK_INDEX_BITS_I;
        end
        else if (READ_ANYTIME_I)
        begin
            next_status[BIT_BSYNC] = BLOCK_SYNC_FLAG_I;
            next_status[BIT_FSYNC] = FRAME_SYNC_FLAG_I;
        end
        next_status[BIT_CHECK_PASS] = next_pass;
        next_rdata = READ_ZERO;
        if (RD_I)
        begin
            unique case (ADDR_I)
                ADDR_STATUS:    next_rdata = next_status;
                ADDR_BLOCK_NUM: next_rdata = next_block_num;
                default:        next_rdata = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            status    <= STATUS_RESET;
            block_num <= BLOCK_NUM_RESET;
            check     <= CHECK_RESET;
            int_n     <= 1'b1;
            pass      <= 1'b1;
            rdata     <= READ_ZERO;
        end
        else
        begin
            status    <= next_status;
            block_num <= next_block_num;
            check     <= next_check;
            int_n     <= next_int_n;
            pass      <= next_pass;
            rdata     <= next_rdata;
        end
    end

    assign RDATA_O            = rdata;
    assign INT_N_O            = int_n;
    assign GROUP_CHECK_PASS_O = pass;

    ////////////////////////////////////////////////////////////////////////////
    property p_load_on_fall;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (int_n && !next_int_n) |=> (block_num == $past(BLOCK_INDEX_BITS_I)
            && status[BIT_ERROR] == $past(BLOCK_ERROR_I));
    endproperty
    a_load_on_fall: assert property (p_load_on_fall) else $error("no load on fall");
    property p_hold;
        @(posedge CLK_I) disable iff (!RST_N_I)
        !(int_n && !next_int_n) |=> $stable(block_num);
    endproperty
    a_hold: assert property (p_hold) else $error("number changed off fall");
    property p_pass_zero;
        @(posedge CLK_I) disable iff (!RST_N_I)
        pass == (check == CHECK_RESET) && status[BIT_CHECK_PASS] == pass;
    endproperty
    a_pass_zero: assert property (p_pass_zero) else $error("pass mismatch");
    property p_clear;
        @(posedge CLK_I) disable iff (!RST_N_I)
        GROUP_CHECK_CLEAR_I |=> check == CHECK_RESET && pass;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_byte;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (WR_I && ADDR_I == ADDR_CHECK_DATA && !GROUP_CHECK_CLEAR_I && check == CHECK_RESET
            && WDATA_I == CHECK_UNIT_BYTE) |=> check == CHECK_POLY;
    endproperty
    a_byte: assert property (p_byte) else $error("crc step wrong");
    property p_int;
        @(posedge CLK_I) disable iff (!RST_N_I)
        BLOCK_READY_I |=> !INT_N_O;
    endproperty
    a_int: assert property (p_int) else $error("no request");
    property p_vpass;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (int_n && !next_int_n) |=> status[BIT_VPASS] == $past(VERTICAL_PASS_FLAG_I)
            && status[BIT_HEAD] == $past(FRAME_HEAD_I);
    endproperty
    a_vpass: assert property (p_vpass) else $error("flags not loaded");
    property p_read;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == ADDR_BLOCK_NUM) |=> RDATA_O == block_num;
    endproperty
    a_read: assert property (p_read) else $error("read wrong");

    ////////////////////////////////////////////////////////////////////////////
    // per-bit load checks: each flag is latched only from its own pin
    property p_load_bsync;
        @(posedge CLK_I) disable iff (!RST_N_I)
        int_fall |=> status[BIT_BSYNC] == $past(BLOCK_SYNC_FLAG_I);
    endproperty
    a_load_bsync: assert property (p_load_bsync) else $error("block sync not loaded");

    property p_load_fsync;
        @(posedge CLK_I) disable iff (!RST_N_I)
        int_fall |=> status[BIT_FSYNC] == $past(FRAME_SYNC_FLAG_I);
    endproperty
    a_load_fsync: assert property (p_load_fsync) else $error("frame sync not loaded");

    property p_load_error;
        @(posedge CLK_I) disable iff (!RST_N_I)
        int_fall |=> status[BIT_ERROR] == $past(BLOCK_ERROR_I);
    endproperty
    a_load_error: assert property (p_load_error) else $error("error bit not loaded");

    property p_load_parity;
        @(posedge CLK_I) disable iff (!RST_N_I)
        int_fall |=> status[BIT_PARITY] == $past(PARITY_BLOCK_FLAG_I);
    endproperty
    a_load_parity: assert property (p_load_parity) else $error("parity not loaded");

    property p_load_head;
        @(posedge CLK_I) disable iff (!RST_N_I)
        int_fall |=> status[BIT_HEAD] == $past(FRAME_HEAD_I);
    endproperty
    a_load_head: assert property (p_load_head) else $error("head not loaded");

    property p_load_realtime;
        @(posedge CLK_I) disable iff (!RST_N_I)
        int_fall |=> status[BIT_REALTIME] == $past(REALTIME_BLOCK_FLAG_I);
    endproperty
    a_load_realtime: assert property (p_load_realtime) else $error("realtime not loaded");

    ////////////////////////////////////////////////////////////////////////////
    // latched copy must not drift between requests
    property p_status_hold;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (!int_fall && !READ_ANYTIME_I) |=> $stable(status[BIT_VPASS:BIT_HEAD])
            && $stable(status[BIT_REALTIME]);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status changed off fall");

    property p_vpass_hold;
        @(posedge CLK_I) disable iff (!RST_N_I)
        !int_fall |=> $stable(status[BIT_VPASS]);
    endproperty
    a_vpass_hold: assert property (p_vpass_hold) else $error("pass kind drifted");

    // live mode only touches the two sync bits
    property p_live_bsync;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (READ_ANYTIME_I && !int_fall) |=> status[BIT_BSYNC] == $past(BLOCK_SYNC_FLAG_I);
    endproperty
    a_live_bsync: assert property (p_live_bsync) else $error("live block sync stale");

    property p_live_fsync;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (READ_ANYTIME_I && !int_fall) |=> status[BIT_FSYNC] == $past(FRAME_SYNC_FLAG_I);
    endproperty
    a_live_fsync: assert property (p_live_fsync) else $error("live frame sync stale");

    ////////////////////////////////////////////////////////////////////////////
    property p_int_idle;
        @(posedge CLK_I) disable iff (!RST_N_I)
        !BLOCK_READY_I |=> INT_N_O;
    endproperty
    a_int_idle: assert property (p_int_idle) else $error("request without block");

    property p_read_status;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == ADDR_STATUS) |=> RDATA_O == status;
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    // bus idles at zero so a stray sample never looks like a status
    property p_read_idle;
        @(posedge CLK_I) disable iff (!RST_N_I)
        !RD_I |=> RDATA_O == READ_ZERO;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not idle");

    ////////////////////////////////////////////////////////////////////////////
    property p_write_ignored;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (GROUP_CHECK_CLEAR_I && WR_I && ADDR_I == ADDR_CHECK_DATA) |=> check == CHECK_RESET;
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write during clear");

    property p_check_hold;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (!GROUP_CHECK_CLEAR_I && !(WR_I && ADDR_I == ADDR_CHECK_DATA)) |=> $stable(check);
    endproperty
    a_check_hold: assert property (p_check_hold) else $error("check moved without byte");

    property p_pin_status;
        @(posedge CLK_I) disable iff (!RST_N_I)
        GROUP_CHECK_PASS_O == status[BIT_CHECK_PASS];
    endproperty
    a_pin_status: assert property (p_pin_status) else $error("pin and flag differ");

    property p_clear_pin;
        @(posedge CLK_I) disable iff (!RST_N_I)
        GROUP_CHECK_CLEAR_I |=> GROUP_CHECK_PASS_O;
    endproperty
    a_clear_pin: assert property (p_clear_pin) else $error("pass pin low after clear");

    // no disable here: this one looks at the edge that leaves reset
    property p_reset_values;
        @(posedge CLK_I)
        $rose(RST_N_I) |-> status == STATUS_RESET && block_num == BLOCK_NUM_RESET && pass;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
endmodule // blkstat_regs
`default_nettype wire

// [test_corrected_data_status_crc_check.sv]
// self-checking bench for the block status and group check registers
// assumes the host model drives the register strobes
`timescale 1ns/100ps
`default_nettype none
module test_corrected_data_status_crc_check;
    import blkstat_pkg::*;
    logic       clk, rst_n, ready, anytime, clr, rd, wr, int_n, pass;
    logic [6:0] flg;
    logic [7:0] idx, rdata, wdata, q, b, exp_stat, exp_num;
    logic [3:0] addr;
    int         bad_count, comparisons, crc, t;

    blkstat_regs dut_u (.CLK_I(clk), .RST_N_I(rst_n), .BLOCK_READY_I(ready),
        .VERTICAL_PASS_FLAG_I(flg[6]), .BLOCK_SYNC_FLAG_I(flg[5]), .FRAME_SYNC_FLAG_I(flg[4]),
        .BLOCK_ERROR_I(flg[3]), .PARITY_BLOCK_FLAG_I(flg[2]), .FRAME_HEAD_I(flg[1]),
        .REALTIME_BLOCK_FLAG_I(flg[0]), .BLOCK_INDEX_BITS_I(idx), .READ_ANYTIME_I(anytime),
        .GROUP_CHECK_CLEAR_I(clr), .RD_I(rd), .WR_I(wr), .ADDR_I(addr), .WDATA_I(wdata),
        .RDATA_O(rdata), .INT_N_O(int_n), .GROUP_CHECK_PASS_O(pass));
    blkstat_host host_u (.clk_i(clk), .rdata_i(rdata), .rd_o(rd), .wr_o(wr), .addr_o(addr),
        .wdata_o(wdata));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // bounded wait on the request line; a hang ends the run
    task automatic wait_int(input logic lvl);
        int k;
        k = 0;
        while (int_n !== lvl && k < 20)
        begin
            @(posedge clk);
            #1 k++;
        end
        if (k == 20)
        begin
            bad_count++;
            end_sim();
        end
    endtask

    // msb-first shift, no reflection, so appending the remainder gives zero
    function automatic int crc_step(int c, logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            c = ((c << 1) ^ ((c[15] ^ d[i]) ? 32'h1021 : 32'h0)) & 32'hFFFF;
        return c;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, ready, anytime, clr} = 4'h0;
        flg = 7'h00;
        idx = 8'h00;
        void'($urandom(32'h337B));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        host_u.access(1'b0, ADDR_STATUS, 8'h00, q);
        check("status", q, STATUS_RESET);
        host_u.access(1'b0, ADDR_BLOCK_NUM, 8'h00, q);
        check("number", q, BLOCK_NUM_RESET);
        check("pass pin", {7'h00, pass}, 8'h01);
        host_u.access(1'b0, 4'h3, 8'h00, q);
        check("unmapped", q, READ_ZERO);
        for (int n = 0; n < 24; n++)
        begin
            @(posedge clk);
            flg <= 7'($urandom);
            idx <= 8'($urandom_range(81));
            ready <= 1'b1;
            wait_int(1'b0);
            exp_stat = {flg[6:1], 1'b1, flg[0]};
            exp_num = idx;
            // flags move after the load and must not leak into the latched copy
            @(posedge clk);
            flg <= ~flg;
            ready <= 1'b0;
            host_u.access(1'b0, ADDR_STATUS, 8'h00, q);
            check("status", q, exp_stat);
            host_u.access(1'b0, ADDR_BLOCK_NUM, 8'h00, q);
            check("number", q, exp_num);
            wait_int(1'b1);
        end
        @(posedge clk);
        anytime <= 1'b1;
        for (int n = 0; n < 2; n++)
        begin
            @(posedge clk);
            flg <= n ? 7'h00 : 7'h20;
            repeat (2) @(posedge clk);
            host_u.access(1'b0, ADDR_STATUS, 8'h00, q);
            check("block sync", {7'h00, q[BIT_BSYNC]}, {7'h00, flg[5]});
        end
        anytime <= 1'b0;
        host_u.access(1'b1, ADDR_CHECK_DATA, 8'hA5, q);
        clr <= 1'b1;
        host_u.access(1'b1, ADDR_CHECK_DATA, 8'($urandom), q);
        repeat (2) @(posedge clk);
        #1 check("pass", {7'h00, pass}, 8'h01);
        clr <= 1'b0;
        crc = 0;
        for (int n = 0; n < 10; n++)
        begin
            if (n == 8)
                t = crc;
            b = (n == 0) ? 8'h01 : (n < 8) ? 8'($urandom) : (n == 8) ? t[15:8] : t[7:0];
            host_u.access(1'b1, ADDR_CHECK_DATA, b, q);
            crc = crc_step(crc, b);
            @(posedge clk);
            #1 check("pass", {7'h00, pass}, {7'h00, crc == 0});
            host_u.access(1'b0, ADDR_STATUS, 8'h00, q);
            check("check bit", {7'h00, q[BIT_CHECK_PASS]}, {7'h00, crc == 0});
        end
        end_sim();
    end
endmodule // test_corrected_data_status_crc_check
`default_nettype wire
